/* logic/instr_exec.sv */
`timescale 1ns/1ns
`default_nettype none
`include "instr_exec_defs.svh"
module instr_exec
    import instr_exec_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire logic [2:0]  op_code,
    input  wire logic [7:0]  literal_k,
    input  wire logic        result_target_sel,
    input  wire logic [7:0]  file_rd_data,
    input  wire logic [12:0] stack_top,
    output logic             op_busy,
    output logic [7:0]       accum,
    output logic [12:0]      prog_counter,
    output logic             stack_pop,
    output logic             file_wr_en,
    output logic [7:0]       file_wr_data,
    output alu_flags_t       alu_flags,
    output pwr_flags_t       pwr_flags,
    output logic [7:0]       watchdog_counter,
    output logic [7:0]       watchdog_prescaler,
    output logic             osc_run
);
    exec_state_t state_reg, state_next;
    logic [7:0]  accum_reg, accum_next;
    logic [12:0] pc_reg, pc_next;
    logic        pop_reg, pop_next;
    logic        fwe_reg, fwe_next;
    logic [7:0]  fwd_reg, fwd_next;
    alu_flags_t  aflg_reg, aflg_next;
    pwr_flags_t  pflg_reg, pflg_next;
    logic [7:0]  wdc_reg, wdc_next;
    logic [7:0]  wdp_reg, wdp_next;
    logic        osc_reg, osc_next;
    logic        busy_reg, busy_next;
    logic [7:0]  sub_a, sub_diff;
    alu_flags_t  sub_flags;

    // literal form subtracts from k, register form from the file byte
    assign sub_a = (op_code == `OP_LIT_SUB) ? literal_k : file_rd_data;

    byte_subtract u_sub (
        .minuend    (sub_a),
        .subtrahend (accum_reg),
        .diff       (sub_diff),
        .flags      (sub_flags)
    );

    // next-state and datapath; sleep holds everything until reset
    always_comb begin
        state_next = state_reg;
        accum_next = accum_reg;
        pc_next    = pc_reg;
        pop_next   = 1'b0;
        fwe_next   = 1'b0;
        fwd_next   = fwd_reg;
        aflg_next  = aflg_reg;
        pflg_next  = pflg_reg;
        wdc_next   = wdc_reg;
        wdp_next   = wdp_reg;
        osc_next   = osc_reg;
        case (state_reg)
            ST_RUN: begin
                if (op_valid) begin
                    case (op_code)
                        `OP_POWERDOWN: begin
                            wdc_next = `WDOG_CLEAR;
                            wdp_next = `PRESC_CLEAR;
                            pflg_next.timeout_flag_n   = 1'b1;
                            pflg_next.powerdown_flag_n = 1'b0;
                            osc_next   = 1'b0;
                            state_next = ST_SLEEP;
                        end
                        `OP_SUB_RETURN: begin
                            pc_next    = stack_top;
                            pop_next   = 1'b1;
                            state_next = ST_RET2;
                        end
                        `OP_ROTATE_R: begin
                            aflg_next.carry = file_rd_data[0];
                            if (result_target_sel == `TARGET_FILE) begin
                                fwe_next = 1'b1;
                                fwd_next = {aflg_reg.carry, file_rd_data[7:1]};
                            end else begin
                                accum_next = {aflg_reg.carry, file_rd_data[7:1]};
                            end
                        end
                        `OP_LIT_SUB: begin
                            accum_next = sub_diff;
                            aflg_next  = sub_flags;
                        end
                        `OP_REG_SUB: begin
                            aflg_next = sub_flags;
                            if (result_target_sel == `TARGET_FILE) begin
                                fwe_next = 1'b1;
                                fwd_next = sub_diff;
                            end else begin
                                accum_next = sub_diff;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_RET2: begin
                state_next = ST_RUN;   // second cycle of return
            end
            ST_SLEEP: begin
                state_next = ST_SLEEP; // wake-up is outside this block
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        // busy follows the next state so op_busy leaves a flip-flop
        busy_next = (state_next != ST_RUN);
    end

    // registers only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
            accum_reg <= `BYTE_ZERO;
            pc_reg    <= `PC_RESET;
            pop_reg   <= 1'b0;
            fwe_reg   <= 1'b0;
            fwd_reg   <= `BYTE_ZERO;
            aflg_reg  <= '0;
            pflg_reg  <= '{timeout_flag_n: `TIMEOUT_RST, powerdown_flag_n: `POWERDOWN_RST};
            wdc_reg   <= `WDOG_CLEAR;
            wdp_reg   <= `PRESC_CLEAR;
            osc_reg   <= 1'b1;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            accum_reg <= accum_next;
            pc_reg    <= pc_next;
            pop_reg   <= pop_next;
            fwe_reg   <= fwe_next;
            fwd_reg   <= fwd_next;
            aflg_reg  <= aflg_next;
            pflg_reg  <= pflg_next;
            wdc_reg   <= wdc_next;
            wdp_reg   <= wdp_next;
            osc_reg   <= osc_next;
            busy_reg  <= busy_next;
        end
    end

    assign op_busy            = busy_reg;
    assign accum              = accum_reg;
    assign prog_counter       = pc_reg;
    assign stack_pop          = pop_reg;
    assign file_wr_en         = fwe_reg;
    assign file_wr_data       = fwd_reg;
    assign alu_flags          = aflg_reg;
    assign pwr_flags          = pflg_reg;
    assign watchdog_counter   = wdc_reg;
    assign watchdog_prescaler = wdp_reg;
    assign osc_run            = osc_reg;

    // checks
    sleep_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_POWERDOWN) |=>
        (pflg_reg.timeout_flag_n && !pflg_reg.powerdown_flag_n && !osc_reg
         && $stable(aflg_reg)))
        else $error("powerdown flags wrong");
    sleep_wdog_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_POWERDOWN) |=>
        (wdc_reg == `WDOG_CLEAR && wdp_reg == `PRESC_CLEAR))
        else $error("watchdog not cleared");
    sleep_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_SLEEP) |=> (state_reg == ST_SLEEP && !osc_reg))
        else $error("left sleep");
    ret_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_SUB_RETURN) |=>
        (pc_reg == $past(stack_top) && pop_reg && op_busy ##1 !op_busy && !pop_reg))
        else $error("return sequence wrong");
    rot_carry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_ROTATE_R) |=>
        (aflg_reg.carry == $past(file_rd_data[0]) && aflg_reg.zero == $past(aflg_reg.zero)))
        else $error("rotate carry wrong");
    rot_target_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_ROTATE_R && result_target_sel) |=>
        (fwe_reg && fwd_reg == {$past(aflg_reg.carry), $past(file_rd_data[7:1])}))
        else $error("rotate write wrong");
    lit_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_LIT_SUB) |=>
        (accum_reg == 8'($past(literal_k) - $past(accum_reg)) && !fwe_reg))
        else $error("literal subtract wrong");
    reg_sub_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_REG_SUB && !result_target_sel) |=>
        (accum_reg == 8'($past(file_rd_data) - $past(accum_reg))
         && aflg_reg.carry == ($past(file_rd_data) >= $past(accum_reg))))
        else $error("register subtract wrong");
    sub_file_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_REG_SUB && result_target_sel) |=>
        (fwe_reg && $stable(accum_reg) && aflg_reg.zero == (fwd_reg == `BYTE_ZERO)))
        else $error("subtract to file wrong");
    // flag meaning checked against plain unsigned compares
    lit_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_LIT_SUB) |=>
        (aflg_reg.carry == ($past(literal_k) >= $past(accum_reg))
         && aflg_reg.half_borrow_bit == ($past(literal_k[3:0]) >= $past(accum_reg[3:0]))
         && aflg_reg.zero == (accum_reg == `BYTE_ZERO)))
        else $error("literal subtract flags wrong");
    sub_half_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_REG_SUB) |=>
        (aflg_reg.half_borrow_bit == ($past(file_rd_data[3:0]) >= $past(accum_reg[3:0]))
         && aflg_reg.carry == ($past(file_rd_data) >= $past(accum_reg))))
        else $error("register subtract flags wrong");
    rot_accum_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RUN && op_valid && op_code == `OP_ROTATE_R && !result_target_sel) |=>
        (!fwe_reg && accum_reg == {$past(aflg_reg.carry), $past(file_rd_data[7:1])}))
        else $error("rotate into accumulator wrong");
    // a request during the second return cycle must not execute
    ret_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == ST_RET2) |=>
        ($stable(accum_reg) && $stable(aflg_reg) && !fwe_reg && !pop_reg))
        else $error("op taken during return");
endmodule
`default_nettype wire

/* include/instr_exec_defs.svh */
`ifndef INSTR_EXEC_DEFS_SVH
`define INSTR_EXEC_DEFS_SVH
// opcode select codes presented on op_code
`define OP_NONE        3'h0
`define OP_POWERDOWN   3'h1
`define OP_SUB_RETURN  3'h2
`define OP_ROTATE_R    3'h3
`define OP_LIT_SUB     3'h4
`define OP_REG_SUB     3'h5
// target select values
`define TARGET_ACCUM   1'h0
`define TARGET_FILE    1'h1
// reset values and constants
`define WDOG_CLEAR     8'h00
`define PRESC_CLEAR    8'h00
`define BYTE_ZERO      8'h00
`define PC_RESET       13'h0000
// flag reset levels (active-low flags idle high)
`define TIMEOUT_RST    1'h1
`define POWERDOWN_RST  1'h1
// cycles a subroutine exit occupies
`define RETURN_CYCLES  2'h2
`endif

/* include/instr_exec_pkg.sv */
package instr_exec_pkg;
    // arithmetic status flags
    typedef struct packed {
        logic zero;
        logic half_borrow_bit;
        logic carry;
    } alu_flags_t;
    // power status flags, both active low
    typedef struct packed {
        logic timeout_flag_n;
        logic powerdown_flag_n;
    } pwr_flags_t;
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_RET2   = 2'b01,
        ST_SLEEP  = 2'b10
    } exec_state_t;
endpackage

/* logic/byte_subtract.sv */
`timescale 1ns/1ns
`default_nettype none
`include "instr_exec_defs.svh"
// minuend minus subtrahend with no-borrow style flags
module byte_subtract
    import instr_exec_pkg::*;
(
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    output logic      [7:0] diff,
    output alu_flags_t      flags
);
    logic [8:0] full;
    logic [4:0] low;

    // two's complement via add of inverted operand plus one
    always_comb begin
        full                  = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
        low                   = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        diff                  = full[7:0];
        flags.carry           = full[8];        // set when no borrow
        flags.half_borrow_bit = low[4];
        flags.zero            = (full[7:0] == `BYTE_ZERO);
    end
endmodule
`default_nettype wire

/* sim/powerdown_return_rotate_subtract_ops_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "instr_exec_defs.svh"
module powerdown_return_rotate_subtract_ops_tb
    import instr_exec_pkg::*;
;
    logic        clk_sys;
    logic        rst_n;
    logic        op_valid;
    logic [2:0]  op_code;
    logic [7:0]  literal_k;
    logic        result_target_sel;
    logic [7:0]  file_rd_data;
    logic [12:0] stack_top;
    logic        op_busy;
    logic [7:0]  accum;
    logic [12:0] prog_counter;
    logic        stack_pop;
    logic        file_wr_en;
    logic [7:0]  file_wr_data;
    alu_flags_t  alu_flags;
    pwr_flags_t  pwr_flags;
    logic [7:0]  watchdog_counter;
    logic [7:0]  watchdog_prescaler;
    logic        osc_run;
    int          fails;
    int          tests_run;
    int          cycles;

    instr_exec i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
        .op_code(op_code), .literal_k(literal_k), .result_target_sel(result_target_sel),
        .file_rd_data(file_rd_data), .stack_top(stack_top), .op_busy(op_busy),
        .accum(accum), .prog_counter(prog_counter), .stack_pop(stack_pop),
        .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .alu_flags(alu_flags),
        .pwr_flags(pwr_flags), .watchdog_counter(watchdog_counter),
        .watchdog_prescaler(watchdog_prescaler), .osc_run(osc_run));

    // 100 MHz core clock
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the roughly 40 cycles the run needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // one request held across its taking edge; results are read just after it
    task automatic do_op(input logic [2:0] code, input logic [7:0] k, input logic sel,
                         input logic [7:0] f);
        @(posedge clk_sys);
        #1;
        op_valid = 1'h1;
        op_code = code;
        literal_k = k;
        result_target_sel = sel;
        file_rd_data = f;
        @(posedge clk_sys);
        #1;
        op_valid = 1'h0;
        file_rd_data = ~f; // released bus must not keep the old value
    endtask

    task automatic lit_step(input logic [7:0] k, input logic [7:0] acc, input logic [2:0] fl);
        do_op(`OP_LIT_SUB, k, 1'h1, 8'h00);
        check(accum, acc, "literal subtract result");
        check(alu_flags, fl, "literal subtract flags");
        check(file_wr_en, 1'h0, "literal subtract wrote file");
    endtask

    task automatic test_lit_sub();
        lit_step(8'h05, 8'h05, 3'h3);
        lit_step(8'h05, 8'h00, 3'h7);
        lit_step(8'h03, 8'h03, 3'h3);
        lit_step(8'h10, 8'h0d, 3'h1);
        lit_step(8'h02, 8'hf5, 3'h0);
        lit_step(8'hf8, 8'h03, 3'h3);
        check(pwr_flags, 2'h3, "power flags moved");
    endtask

    task automatic test_reg_sub();
        do_op(`OP_REG_SUB, 8'h00, `TARGET_FILE, 8'h05);
        check(file_wr_en, 1'h1, "subtract file write");
        check(file_wr_data, 8'h02, "subtract file data");
        check(accum, 8'h03, "accumulator touched");
        check(alu_flags, 3'h3, "subtract flags");
        do_op(`OP_REG_SUB, 8'h00, `TARGET_ACCUM, 8'h03);
        check(accum, 8'h00, "subtract into accumulator");
        check(file_wr_en, 1'h0, "file written for target 0");
        check(alu_flags, 3'h7, "zero result flags");
    endtask

    task automatic test_rotate();
        do_op(`OP_ROTATE_R, 8'h00, `TARGET_FILE, 8'h80);
        check(file_wr_data, 8'hc0, "old carry into top bit");
        check(file_wr_en, 1'h1, "rotate file write");
        check(alu_flags, 3'h6, "only carry changes");
        check(accum, 8'h00, "accumulator touched");
        do_op(`OP_ROTATE_R, 8'h00, `TARGET_ACCUM, 8'h03);
        check(accum, 8'h01, "rotate into accumulator");
        check(file_wr_en, 1'h0, "file written for target 0");
        check(alu_flags, 3'h7, "low bit into carry");
    endtask

    // a request held through the busy cycle must be ignored
    task automatic test_return();
        stack_top = 13'h1abc;
        @(posedge clk_sys);
        #1;
        op_valid = 1'h1;
        op_code = `OP_SUB_RETURN;
        @(posedge clk_sys);
        #1;
        op_code = `OP_LIT_SUB;
        literal_k = 8'h55;
        check(prog_counter, 13'h1abc, "pc from stack top");
        check(stack_pop, 1'h1, "stack popped");
        check(op_busy, 1'h1, "second cycle busy");
        check(alu_flags, 3'h7, "return changed flags");
        @(posedge clk_sys);
        #1;
        op_valid = 1'h0;
        stack_top = 13'h0543;
        check(stack_pop, 1'h0, "pop longer than one cycle");
        check(op_busy, 1'h0, "busy past two cycles");
        check(accum, 8'h01, "op taken while busy");
    endtask

    task automatic test_powerdown();
        do_op(`OP_POWERDOWN, 8'h00, 1'h0, 8'h00);
        check(watchdog_counter, 8'h00, "watchdog not cleared");
        check(watchdog_prescaler, 8'h00, "prescaler not cleared");
        check(pwr_flags, 2'h2, "power flags");
        check(alu_flags, 3'h7, "other status changed");
        check(osc_run, 1'h0, "oscillator running");
        check(prog_counter, 13'h1abc, "pc moved without return");
        do_op(`OP_LIT_SUB, 8'h99, 1'h0, 8'h00);
        check(op_busy, 1'h1, "left sleep");
        check(accum, 8'h01, "op run in sleep");
        rst_n = 1'h0;
        #1;
        check(osc_run, 1'h1, "reset left oscillator stopped");
        check(pwr_flags, 2'h3, "power flags reset level");
        @(posedge clk_sys);
        #1;
        rst_n = 1'h1;
        check(op_busy, 1'h0, "sleep survived reset");
    endtask

    // main sequence: reset held 12 cycles, then each scenario
    initial begin
        rst_n = 1'h0;
        op_valid = 1'h0;
        op_code = `OP_NONE;
        literal_k = 8'h00;
        result_target_sel = 1'h0;
        file_rd_data = 8'h00;
        stack_top = 13'h0000;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        repeat (12) @(posedge clk_sys);
        #1;
        rst_n = 1'h1;
        check(accum, 8'h00, "accumulator reset");
        check(osc_run, 1'h1, "oscillator reset");
        test_lit_sub();
        test_reg_sub();
        test_rotate();
        test_return();
        test_powerdown();
        give_verdict();
    end
endmodule
`default_nettype wire
